// [src/rst_seq_dev.sv]
// Display-side reset qualifier, blanking and settings reload sequencer.
// Assumes hw_reset_n is asynchronous to ref_clk_i; nvm reload handshake from user side.
`timescale 1ns/10ps
`default_nettype none
`include "rst_seq_defines.svh"
module rst_seq_dev
    import rst_seq_pkg::*;
#(
    parameter int unsigned SLEEP_REL_CYCLES = `SLEEP_REL_CYC,
    parameter int unsigned AWAKE_REL_CYCLES = `AWAKE_REL_CYC
) (
    // Clock, reset, enable
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    // Link
    rst_seq_if.dev link,
    // User side
    input wire logic sleep_out_i,
    input wire logic blank_done_i,
    input wire logic reload_done_i,
    output logic blank_o,
    output logic reload_start_o,
    output logic in_reset_o,
    output logic ready_o,
    output logic timeout_o,
    output pulse_class_t pulse_class_o
);
    typedef enum logic [2:0] {S_RUN, S_LOW, S_BLANK, S_WAIT_HI, S_RELOAD} state_t;
    state_t state;
    state_t next_state;
    logic sync1;
    logic sync2;
    logic [31:0] low_cnt;
    logic [31:0] hi_cnt;
    logic [31:0] rel_cnt;
    logic was_awake;
    wire line_low = ~sync2;
    // A high glitch shorter than this is absorbed into the pulse
    wire glitch_over = hi_cnt >= 32'(`GLITCH_CYC);
    wire qualified = low_cnt >= 32'(`REJECT_CYC);
    wire rel_limit = was_awake ? (rel_cnt >= AWAKE_REL_CYCLES) : (rel_cnt >= SLEEP_REL_CYCLES);

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            sync1 <= 1'b1;
            sync2 <= 1'b1;
        end else if (clk_en_i) begin
            sync1 <= link.hw_reset_n;
            sync2 <= sync1;
        end
    end

    // Pulse width measurement, glitch tolerant once qualified
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            low_cnt <= 32'h0000_0000;
            hi_cnt <= 32'h0000_0000;
        end else if (clk_en_i) begin
            if (line_low) begin
                hi_cnt <= 32'h0000_0000;
                if (low_cnt != 32'hFFFF_FFFF) begin
                    low_cnt <= low_cnt + 32'h0000_0001;
                end
            end else if (state == S_LOW && !glitch_over) begin
                hi_cnt <= hi_cnt + 32'h0000_0001;
            end else if (state != S_LOW) begin
                low_cnt <= 32'h0000_0000;
                hi_cnt <= 32'h0000_0000;
            end
        end
    end

    always_comb begin
        next_state = state;
        unique case (state)
            S_RUN: if (line_low && qualified) next_state = S_LOW;
            S_LOW: if (!line_low && glitch_over) next_state = S_BLANK;
            S_BLANK: if (!was_awake || blank_done_i || rel_limit) next_state = S_RELOAD;
            S_WAIT_HI: next_state = S_RELOAD;
            S_RELOAD: if (reload_done_i || rel_limit) next_state = S_RUN;
        endcase
        if (state != S_LOW && state != S_RUN && line_low && qualified) begin
            next_state = S_LOW;
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            state <= S_RUN;
            was_awake <= 1'b0;
            rel_cnt <= 32'h0000_0000;
            blank_o <= 1'b0;
            reload_start_o <= 1'b0;
            in_reset_o <= 1'b0;
            ready_o <= 1'b0;
            timeout_o <= 1'b0;
            pulse_class_o <= PULSE_NONE;
        end else if (clk_en_i) begin
            state <= next_state;
            reload_start_o <= 1'b0;
            if (state == S_RUN && next_state == S_LOW) begin
                was_awake <= sleep_out_i;
                blank_o <= 1'b1;
                in_reset_o <= 1'b1;
                ready_o <= 1'b0;
                timeout_o <= 1'b0;
            end
            if (state == S_LOW && next_state == S_BLANK) begin
                rel_cnt <= 32'h0000_0000;
                // Full reset only past 10 us; shorter qualified pulses are partial
                pulse_class_o <= (low_cnt > 32'(`FULL_CYC)) ? PULSE_FULL : PULSE_PARTIAL;
            end else if (state != S_RUN) begin
                rel_cnt <= rel_cnt + 32'h0000_0001;
            end
            if (state == S_RUN && !line_low && low_cnt != 32'h0000_0000 && !qualified) begin
                pulse_class_o <= PULSE_REJECT;
            end
            if (next_state == S_RELOAD && state != S_RELOAD) begin
                reload_start_o <= 1'b1;
            end
            if (state == S_RELOAD && next_state == S_RUN) begin
                in_reset_o <= 1'b0;
                blank_o <= 1'b0;
                ready_o <= 1'b1;
                timeout_o <= rel_limit && !reload_done_i;
                was_awake <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// [common/rst_seq_defines.svh]
// Timing constants and format codes for the display reset sequencer pair.
// Assumes a 125 MHz core clock on both ends.
// Contract
// - Low pulses under 5 us are ignored
// - Pulses over 10 us fully reset device
// - Pulses 5 to 10 us start reset
// - Reload stored settings after every reset release
// - Release within 5 ms when sleeping
// - Release within 120 ms when awake
// - Blank display during reset, then defaults
// - Short high glitch inside reset ignored
// - Host waits 5 ms before commands
// - Host waits 120 ms before wake command
// - Format codes 0E 1E 2E 3E
// - Host keeps lane rate within format limit (code only flags it on rate_ok_o)
`ifndef RST_SEQ_DEFINES_SVH
`define RST_SEQ_DEFINES_SVH
`define CLK_MHZ 125
`define REJECT_US 5
`define FULL_US 10
`define SLEEP_REL_MS 5
`define AWAKE_REL_MS 120
`define CMD_WAIT_MS 5
`define WAKE_WAIT_MS 120
`define GLITCH_NS 1000
`define REJECT_CYC (`REJECT_US * `CLK_MHZ)
`define FULL_CYC (`FULL_US * `CLK_MHZ)
`define GLITCH_CYC ((`GLITCH_NS * `CLK_MHZ) / 1000)
`define SLEEP_REL_CYC (`SLEEP_REL_MS * 1000 * `CLK_MHZ)
`define AWAKE_REL_CYC (`AWAKE_REL_MS * 1000 * `CLK_MHZ)
`define CMD_WAIT_CYC (`CMD_WAIT_MS * 1000 * `CLK_MHZ)
`define WAKE_WAIT_CYC (`WAKE_WAIT_MS * 1000 * `CLK_MHZ)
`define HOLD_CYC (`FULL_CYC + 2 * `GLITCH_CYC)
`define DT_565 8'h0E
`define DT_666P 8'h1E
`define DT_666L 8'h2E
`define DT_888 8'h3E
`define RATE_565_2L 16'h0236
`define RATE_565_3L 16'h01D2
`define RATE_565_4L 16'h016E
`define RATE_666_2L 16'h027D
`define RATE_666_3L 16'h020D
`define RATE_666_4L 16'h019C
`define RATE_24_2L 16'h0352
`define RATE_24_3L 16'h02BC
`define RATE_24_4L 16'h0226
`endif

// [common/rst_seq_pkg.sv]
// Types shared by the reset sequencer ends.
// Used with rst_seq_defines.svh.
package rst_seq_pkg;
    typedef enum logic [1:0] {FMT_565, FMT_666P, FMT_666L, FMT_888} pix_fmt_t;
    typedef enum logic [1:0] {PULSE_NONE, PULSE_REJECT, PULSE_PARTIAL, PULSE_FULL} pulse_class_t;
endpackage

// [common/rst_seq_if.sv]
// Link between host and display: the active-low reset line.
// The host drives it; the display only samples.
`timescale 1ns/10ps
`default_nettype none
interface rst_seq_if;
    logic hw_reset_n;
    modport host (output hw_reset_n);
    modport dev (input hw_reset_n);
endinterface
`default_nettype wire

// [src/rst_seq_host.sv]
// Host-side reset pulse generator with command and wake hold-offs.
// Assumes the display end samples the line; format check on the user side.
`timescale 1ns/10ps
`default_nettype none
`include "rst_seq_defines.svh"
module rst_seq_host
    import rst_seq_pkg::*;
#(
    parameter int unsigned CMD_WAIT_CYCLES = `CMD_WAIT_CYC,
    parameter int unsigned WAKE_WAIT_CYCLES = `WAKE_WAIT_CYC
) (
    // Clock, reset, enable
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    // Link
    rst_seq_if.host link,
    // User side
    input wire logic do_reset_i,
    input wire pix_fmt_t fmt_i,
    input wire logic [1:0] lanes_i,
    input wire logic [15:0] lane_rate_i,
    output logic busy_o,
    output logic cmd_ok_o,
    output logic wake_ok_o,
    output logic [7:0] data_type_o,
    output logic rate_ok_o
);
    logic [31:0] cnt;
    logic holding;
    logic [15:0] limit;
    always_comb begin
        limit = `RATE_24_4L;
        unique case (fmt_i)
            FMT_565: limit = (lanes_i == 2'd2) ? `RATE_565_2L : (lanes_i == 2'd3) ? `RATE_565_3L : `RATE_565_4L;
            FMT_666P: limit = (lanes_i == 2'd2) ? `RATE_666_2L : (lanes_i == 2'd3) ? `RATE_666_3L : `RATE_666_4L;
            default: limit = (lanes_i == 2'd2) ? `RATE_24_2L : (lanes_i == 2'd3) ? `RATE_24_3L : `RATE_24_4L;
        endcase
    end
    wire [7:0] dt_sel = (fmt_i == FMT_565) ? `DT_565 : (fmt_i == FMT_666P) ? `DT_666P :
                        (fmt_i == FMT_666L) ? `DT_666L : `DT_888;

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            link.hw_reset_n <= 1'b1;
            holding <= 1'b0;
            cnt <= 32'h0000_0000;
            busy_o <= 1'b0;
            cmd_ok_o <= 1'b0;
            wake_ok_o <= 1'b0;
            data_type_o <= `DT_888;
            rate_ok_o <= 1'b0;
        end else if (clk_en_i) begin
            data_type_o <= dt_sel;
            rate_ok_o <= lane_rate_i <= limit;
            if (do_reset_i && !busy_o) begin
                link.hw_reset_n <= 1'b0;
                holding <= 1'b1;
                busy_o <= 1'b1;
                cmd_ok_o <= 1'b0;
                wake_ok_o <= 1'b0;
                cnt <= 32'h0000_0000;
            end else if (holding) begin
                cnt <= cnt + 32'h0000_0001;
                // Margin over the full-reset width covers sampling skew
                if (cnt >= 32'(`HOLD_CYC)) begin
                    link.hw_reset_n <= 1'b1;
                    holding <= 1'b0;
                    cnt <= 32'h0000_0000;
                end
            end else if (busy_o) begin
                cnt <= cnt + 32'h0000_0001;
                if (cnt >= CMD_WAIT_CYCLES) cmd_ok_o <= 1'b1;
                if (cnt >= WAKE_WAIT_CYCLES) begin
                    wake_ok_o <= 1'b1;
                    busy_o <= 1'b0;
                end
            end
        end
    end
endmodule
`default_nettype wire

// [tb/rst_seq_checker.sv]
// Concurrent checks on the first host-to-display link and both of its ends.
// Instantiated by the bench beside that link; hold-offs come in shortened.
`timescale 1ns/10ps
`default_nettype none
module rst_seq_checker #(
    parameter int unsigned CMD_WAIT_CYCLES = 100,
    parameter int unsigned WAKE_WAIT_CYCLES = 300
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // Link and observed outputs
    input wire logic hw_reset_n,
    input wire logic in_reset_o,
    input wire logic blank_o,
    input wire logic reload_start_o,
    input wire logic busy_o,
    input wire logic cmd_ok_o,
    input wire logic wake_ok_o
);
    logic [11:0] low_cnt;
    logic [11:0] high_cnt;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    // high_cnt saturates so a long idle line never wraps back under the hold-offs
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            low_cnt <= '0;
            high_cnt <= '0;
        end else begin
            low_cnt <= hw_reset_n ? '0 : low_cnt + 1'b1;
            high_cnt <= !hw_reset_n ? '0 : high_cnt + {11'h000, ~&high_cnt};
        end
    end
    property p_hold; $rose(hw_reset_n) |-> low_cnt >= 12'h4E2; endproperty
    a_hold: assert property (p_hold) else $error("line released early");
    property p_busy; !hw_reset_n |-> busy_o; endproperty
    a_busy: assert property (p_busy) else $error("line low while idle");
    property p_reject; $rose(in_reset_o) |-> low_cnt >= 12'h271; endproperty
    a_reject: assert property (p_reject) else $error("short pulse taken");
    property p_start; low_cnt == 12'h280 |-> in_reset_o; endproperty
    a_start: assert property (p_start) else $error("reset not started");
    property p_blank; in_reset_o |-> blank_o; endproperty
    a_blank: assert property (p_blank) else $error("panel not blanked");
    property p_reload; reload_start_o |-> hw_reset_n ##1 !reload_start_o; endproperty
    a_reload: assert property (p_reload) else $error("bad reload start");
    property p_release; $rose(hw_reset_n) |-> ##[1:600] !in_reset_o; endproperty
    a_release: assert property (p_release) else $error("release too slow");
    property p_cmd; cmd_ok_o && hw_reset_n |-> high_cnt >= CMD_WAIT_CYCLES - 2; endproperty
    a_cmd: assert property (p_cmd) else $error("command allowed early");
    property p_wake; wake_ok_o && hw_reset_n |-> high_cnt >= WAKE_WAIT_CYCLES - 2; endproperty
    a_wake: assert property (p_wake) else $error("wake allowed early");
endmodule
`default_nettype wire

// [tb/display_reset_init_sequencer_bench.sv]
// Host and display ends on one link, plus a second display end whose
// line the bench drives directly. Waits on the first link shortened by parameters.
`timescale 1ns/10ps
`default_nettype none
module display_reset_init_sequencer_bench;
    import rst_seq_pkg::*;
    logic ref_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic do_reset_i = 1'b0;
    pix_fmt_t fmt_i = FMT_565;
    logic [1:0] lanes_i = 2'h2;
    logic [15:0] lane_rate_i = 16'h0000;
    logic sleep_out_i = 1'b0;
    logic ack = 1'b0;
    logic clk_en = 1'b1;
    logic blank_done = 1'b0;
    logic reload_done_i = 1'b0;
    logic busy_o, cmd_ok_o, wake_ok_o, rate_ok_o, rs_a, rs_b, in_a, in_b, blank_a, ready_a, tmo_a;
    logic [7:0] data_type_o;
    pulse_class_t cls_a, cls_b;
    logic [15:0] lim [6] = '{16'h0236, 16'h01D2, 16'h016E, 16'h0352, 16'h02BC, 16'h0226};
    int failures = 0;
    int n_compared = 0;
    int i;
    rst_seq_if link_a ();
    rst_seq_if link_b ();
    rst_seq_host #(.CMD_WAIT_CYCLES(100), .WAKE_WAIT_CYCLES(300)) rst_seq_host_i (.ref_clk_i(ref_clk_i),
        .reset_i(reset_i), .clk_en_i(clk_en), .link(link_a.host), .do_reset_i(do_reset_i), .fmt_i(fmt_i),
        .lanes_i(lanes_i), .lane_rate_i(lane_rate_i), .busy_o(busy_o), .cmd_ok_o(cmd_ok_o),
        .wake_ok_o(wake_ok_o), .data_type_o(data_type_o), .rate_ok_o(rate_ok_o));
    rst_seq_dev #(.SLEEP_REL_CYCLES(200), .AWAKE_REL_CYCLES(400)) rst_seq_dev_i (.ref_clk_i(ref_clk_i),
        .reset_i(reset_i), .clk_en_i(clk_en), .link(link_a.dev), .sleep_out_i(sleep_out_i),
        .blank_done_i(blank_done),
        .reload_done_i(reload_done_i), .blank_o(blank_a), .reload_start_o(rs_a), .in_reset_o(in_a),
        .ready_o(ready_a), .timeout_o(tmo_a), .pulse_class_o(cls_a));
    // Second end keeps full release limits; its qualified pulses all end by reload_done
    rst_seq_dev rst_seq_dev_2_i (.ref_clk_i(ref_clk_i),
        .reset_i(reset_i), .clk_en_i(clk_en), .link(link_b.dev), .sleep_out_i(sleep_out_i),
        .blank_done_i(blank_done),
        .reload_done_i(reload_done_i), .blank_o(), .reload_start_o(rs_b), .in_reset_o(in_b),
        .ready_o(), .timeout_o(), .pulse_class_o(cls_b));
    rst_seq_checker rst_seq_checker_i (.ref_clk_i(ref_clk_i),
        .reset_i(reset_i), .hw_reset_n(link_a.hw_reset_n), .in_reset_o(in_a), .blank_o(blank_a),
        .reload_start_o(rs_a), .busy_o(busy_o), .cmd_ok_o(cmd_ok_o), .wake_ok_o(wake_ok_o));
    always #4 ref_clk_i = ~ref_clk_i;
    // Settings memory answers each reload start one cycle later when enabled
    always @(negedge ref_clk_i) reload_done_i <= ack & (rs_a | rs_b);
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask
    task automatic line_b(input logic v, input int n);
        link_b.hw_reset_n = v;
        cyc(n);
    endtask
    task automatic host_pulse();
        do_reset_i = 1'b1;
        cyc(1);
        do_reset_i = 1'b0;
        cyc(2);
        for (i = 0; i < 2000 && link_a.hw_reset_n !== 1'b1; i++) cyc(1);
    endtask
    task automatic wrap_up();
        $display("compared %0d failed %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        cyc(20000);
        failures++;
        wrap_up();
    end
    initial begin
        link_b.hw_reset_n = 1'b1;
        cyc(10);
        reset_i = 1'b0;
        cyc(2);
        // A request while the enable is low must not be taken
        clk_en = 1'b0;
        do_reset_i = 1'b1;
        cyc(3);
        chk(busy_o, 1'b0);
        do_reset_i = 1'b0;
        clk_en = 1'b1;
        cyc(2);
        chk(busy_o, 1'b0);
        for (i = 0; i < 4; i++) begin
            fmt_i = pix_fmt_t'(i);
            cyc(2);
            chk(data_type_o, {2'h0, i[1:0], 4'hE});
        end
        for (i = 0; i < 6; i++) begin
            fmt_i = i < 3 ? FMT_565 : FMT_888;
            lanes_i = 2'(i % 3 + 2);
            lane_rate_i = lim[i];
            cyc(2);
            chk(rate_ok_o, 1'b1);
            lane_rate_i = lim[i] + 16'h0001;
            cyc(2);
            chk(rate_ok_o, 1'b0);
        end
        line_b(1'b0, 600);
        line_b(1'b1, 200);
        chk(cls_b, PULSE_REJECT);
        chk(in_b, 1'b0);
        ack = 1'b1;
        line_b(1'b0, 800);
        chk(in_b, 1'b1);
        line_b(1'b1, 400);
        chk(cls_b, PULSE_PARTIAL);
        chk(in_b, 1'b0);
        // A high spike mid-pulse must neither end nor restart the count
        line_b(1'b0, 700);
        line_b(1'b1, 60);
        chk(in_b, 1'b1);
        line_b(1'b0, 700);
        line_b(1'b1, 400);
        chk(cls_b, PULSE_FULL);
        host_pulse();
        cyc(50);
        chk(cmd_ok_o, 1'b0);
        cyc(150);
        chk(ready_a, 1'b1);
        chk(tmo_a, 1'b0);
        chk(cls_a, PULSE_FULL);
        chk(cmd_ok_o, 1'b1);
        chk(wake_ok_o, 1'b0);
        cyc(110);
        chk(wake_ok_o, 1'b1);
        ack = 1'b0;
        sleep_out_i = 1'b1;
        host_pulse();
        cyc(300);
        chk(blank_a, 1'b1);
        cyc(260);
        chk(tmo_a, 1'b1);
        chk(blank_a, 1'b0);
        // Awake again, blanking reported done: release ends without the limit
        ack = 1'b1;
        blank_done = 1'b1;
        host_pulse();
        cyc(200);
        chk(blank_a, 1'b0);
        chk(tmo_a, 1'b0);
        chk(ready_a, 1'b1);
        wrap_up();
    end
endmodule
`default_nettype wire
